// [can_mh_defs.svh]
// register offsets, field positions, identifier codes and compare masks of the message handler
`ifndef CAN_MH_DEFS_SVH
`define CAN_MH_DEFS_SVH
`define MH_CTRL_OFS    12'h000
`define MH_STAT_OFS    12'h004
`define MH_IDR_OFS     12'h010
`define MH_IF_CRR_OFS  12'h020
`define MH_IF_CMR_OFS  12'h024
`define MH_IF_M1R_OFS  12'h028
`define MH_IF_M2R_OFS  12'h02C
`define MH_IF_A1R_OFS  12'h030
`define MH_IF_A2R_OFS  12'h034
`define MH_IF_MCR_OFS  12'h038
`define MH_IF_DA1_OFS  12'h03C
`define MH_IF_DA2_OFS  12'h040
`define MH_IF_DB1_OFS  12'h044
`define MH_IF_DB2_OFS  12'h048
`define MH_TXR_LO_OFS  12'h100
`define MH_TXR_HI_OFS  12'h104
`define MH_NDR_LO_OFS  12'h120
`define MH_NDR_HI_OFS  12'h124
`define MH_IPR_LO_OFS  12'h140
`define MH_IPR_HI_OFS  12'h144
`define MH_MVR_LO_OFS  12'h160
`define MH_MVR_HI_OFS  12'h164
`define MH_CTRL_IE_BIT 1
`define MH_STAT_RX_BIT 4
`define MH_STAT_TX_BIT 3
`define MH_STAT_PD_BIT 0
`define MH_CMD_WR_BIT  7
`define MH_CMD_MSK_BIT 6
`define MH_CMD_ARB_BIT 5
`define MH_CMD_CTL_BIT 4
`define MH_CMD_CLR_BIT 3
`define MH_CMD_TXR_BIT 2
`define MH_CMD_DA_BIT  1
`define MH_CMD_DB_BIT  0
`define MH_IDR_NONE    16'h0000
`define MH_IDR_STATUS  16'h8000
`define MH_MSK_RESET   29'h1FFFFFFF
`define MH_STD_MASK    29'h1FFC0000
`endif

// [can_mh_pkg.sv]
// types shared by the message handler and its surroundings
package can_mh_pkg;
  typedef struct packed {
    logic        valid;  logic xtd;  logic dir;  logic [28:0] id;
    logic        use_accept_mask;  logic mask_extended_flag; logic mask_direction_flag; logic [28:0] msk;
    logic        end_of_buffer;    logic new_data_flag; logic message_lost_flag; logic rx_irq_enable;
    logic        tx_irq_enable;   logic irq_pending_flag; logic remote_answer_enable;  logic transmit_request;
    logic [3:0]  dlc;    logic [63:0] data;
  } msg_obj_t;
  typedef struct packed {
    logic wr; logic rd; logic [11:0] addr; logic [31:0] wdata;
  } bus_req_t;
  typedef struct packed {
    logic strobe; logic ide; logic remote; logic [28:0] id;
    logic [3:0] dlc; logic [63:0] data;
  } rx_frame_t;
  typedef struct packed {
    logic valid; logic [4:0] obj; logic xtd; logic remote; logic [28:0] id;
    logic [3:0] dlc; logic [63:0] data;
  } tx_frame_t;
  typedef struct packed { logic strobe; logic [4:0] obj; } tx_done_t;
  typedef struct packed {
    logic ie; logic stat_pend; logic rx_ok; logic tx_ok;
    logic [7:0] ifcmd; msg_obj_t ifbuf; msg_obj_t [31:0] objs;
    tx_frame_t tx; logic [31:0] rdata;
  } mh_state_t;
endpackage

// [can_message_object_handler.sv]
// message handler: 32 message objects, filtering, flags and summary registers
//
// Operation
// RL1: invalid objects never receive nor transmit
// RL2: software clears valid before reconfiguring objects
// RL3: use-mask selects masks or exact compare
// RL4: software programs masks before setting valid
// RL5: identifier held in bits 28 to 0
// RL6: mask bit zero never blocks a match
// RL7: extended-select picks 29 or 11 bits
// RL8: extended and direction masks gate comparison
// RL9: standard objects compare bits 28 to 18
// RL10: transmit objects send data, answer remotes
// RL11: receive objects send remote, store data
// RL12: end-of-buffer chains objects into FIFO
// RL13: new-data set on write, sticky
// RL14: store over new-data sets message-lost
// RL15: success sets pending when enable set
// RL16: remote-enable lets remote set request
// RL17: length code stored; over 8 means 8
// RL18: byte 0 first, all eight slots written
// RL19: identifier codes none, object, status
// RL20: status first, then lowest object number
// RL21: interrupt out while identifier nonzero and enabled
// RL22: clear pending or read status clears
// RL23: 32 objects reached only through buffer
// RL24: multiple matches go to lowest number
// RL25: summary registers read-only, split low/high
`timescale 1ns/1ns
`include "can_mh_defs.svh"
module can_message_object_handler import can_mh_pkg::*; (
  input  wire logic      CLK,
  input  wire logic      RST,
  input  wire bus_req_t  BUS,
  output logic [31:0]    RDATA,
  input  wire rx_frame_t RX,
  output tx_frame_t      TX,
  input  wire tx_done_t  TX_DONE,
  input  wire logic      STATUS_EVENT,
  output logic           IRQ
);
  // ----------------------------------------------------------------
  // state and summary vectors
  // ----------------------------------------------------------------
  mh_state_t   st_q, st_d;        // whole block state
  logic [31:0] txr_v;             // transmit_request per object
  logic [31:0] ndv_v;             // new_data_flag per object
  logic [31:0] ipd_v;             // irq_pending_flag per object
  logic [31:0] val_v;             // object_valid per object
  logic [31:0] hit_v;             // acceptance filter hits
  logic [31:0] take_v;            // hits that may take the frame
  logic [4:0]  rx_sel;            // object chosen for the frame
  logic        rx_any;            // some object takes the frame
  logic [4:0]  tx_sel;            // object chosen to transmit
  logic        tx_any;            // some object wants to transmit
  logic [15:0] int_id;            // interrupt_identifier
  logic [5:0]  sw_num;            // object number written to the command
  logic [4:0]  sw_idx;            // its array index

  // ----------------------------------------------------------------
  // per-object filter and summaries
  // ----------------------------------------------------------------
  for (genvar g = 0; g < 32; g++) begin : g_obj
    msg_obj_t    o;               // this object
    logic [28:0] em;              // effective compare mask
    assign o      = st_q.objs[g];
    // masks only apply when use_accept_mask is set; standard objects
    // compare nothing below bit 18
    assign em = (o.use_accept_mask ? o.msk : `MH_MSK_RESET) &               // RL3 RL6
                (o.xtd ? `MH_MSK_RESET : `MH_STD_MASK);            // RL7 RL9
    assign hit_v[g] = o.valid &                                    // RL1
                      (((o.id ^ RX.id) & em) == 29'h0) &           // RL5
                      ((o.use_accept_mask & ~o.mask_extended_flag) | (o.xtd == RX.ide)) &  // RL8
                      ((o.use_accept_mask & ~o.mask_direction_flag) | (o.dir == RX.remote));// RL8
    // a full non-final FIFO member passes a data frame onwards; a remote frame is still taken
    assign take_v[g] = hit_v[g] & (RX.remote | ~o.new_data_flag | o.end_of_buffer); // RL12
    assign txr_v[g] = o.transmit_request;
    assign ndv_v[g] = o.new_data_flag;
    assign ipd_v[g] = o.irq_pending_flag;
    assign val_v[g] = o.valid;
  end

  // ----------------------------------------------------------------
  // priority pickers: lowest object number wins everywhere
  // ----------------------------------------------------------------
  always_comb begin
    rx_sel = 5'h0;
    rx_any = 1'b0;
    tx_sel = 5'h0;
    tx_any = 1'b0;
    int_id = `MH_IDR_NONE;
    for (int i = 31; i >= 0; i--) begin
      if (take_v[i]) begin                                         // RL24
        rx_sel = 5'(i);
        rx_any = 1'b1;
      end
      if (txr_v[i] && val_v[i]) begin                              // RL1
        tx_sel = 5'(i);
        tx_any = 1'b1;
      end
      if (ipd_v[i]) begin                                          // RL20
        int_id = 16'(i + 1);                                       // RL19
      end
    end
    if (st_q.stat_pend) begin                                      // RL20
      int_id = `MH_IDR_STATUS;                                     // RL19
    end
  end

  assign IRQ    = st_q.ie && (int_id != `MH_IDR_NONE);             // RL21
  assign RDATA  = st_q.rdata;
  assign TX     = st_q.tx;
  assign sw_num = BUS.wdata[5:0];
  assign sw_idx = 5'(sw_num - 6'h01);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d       = st_q;
    st_d.rdata = 32'h0;
    // transmit completion: clearing part first so a software set wins
    if (TX_DONE.strobe) begin
      st_d.objs[TX_DONE.obj].transmit_request = 1'b0;
      st_d.objs[TX_DONE.obj].new_data_flag = 1'b0;
    end
    // register writes
    if (BUS.wr) begin
      case (BUS.addr)
        `MH_CTRL_OFS:   st_d.ie = BUS.wdata[`MH_CTRL_IE_BIT];
        `MH_IF_CMR_OFS: st_d.ifcmd = BUS.wdata[7:0];
        `MH_IF_M1R_OFS: st_d.ifbuf.msk[15:0] = BUS.wdata[15:0];
        `MH_IF_M2R_OFS: begin
          st_d.ifbuf.mask_extended_flag       = BUS.wdata[15];
          st_d.ifbuf.mask_direction_flag       = BUS.wdata[14];
          st_d.ifbuf.msk[28:16] = BUS.wdata[12:0];
        end
        `MH_IF_A1R_OFS: st_d.ifbuf.id[15:0] = BUS.wdata[15:0];
        `MH_IF_A2R_OFS: begin
          st_d.ifbuf.valid     = BUS.wdata[15];
          st_d.ifbuf.xtd       = BUS.wdata[14];
          st_d.ifbuf.dir       = BUS.wdata[13];
          st_d.ifbuf.id[28:16] = BUS.wdata[12:0];
        end
        `MH_IF_MCR_OFS: begin
          {st_d.ifbuf.new_data_flag, st_d.ifbuf.message_lost_flag, st_d.ifbuf.irq_pending_flag,
           st_d.ifbuf.use_accept_mask, st_d.ifbuf.tx_irq_enable, st_d.ifbuf.rx_irq_enable,
           st_d.ifbuf.remote_answer_enable, st_d.ifbuf.transmit_request, st_d.ifbuf.end_of_buffer} = BUS.wdata[15:7];
          st_d.ifbuf.dlc = BUS.wdata[3:0];
        end
        `MH_IF_DA1_OFS: st_d.ifbuf.data[15:0]  = BUS.wdata[15:0];
        `MH_IF_DA2_OFS: st_d.ifbuf.data[31:16] = BUS.wdata[15:0];
        `MH_IF_DB1_OFS: st_d.ifbuf.data[47:32] = BUS.wdata[15:0];
        `MH_IF_DB2_OFS: st_d.ifbuf.data[63:48] = BUS.wdata[15:0];
        `MH_IF_CRR_OFS: begin
          // software reaches object memory only here, through the buffer   RL23
          if (sw_num != 6'h00 && sw_num <= 6'd32) begin
            if (st_q.ifcmd[`MH_CMD_WR_BIT]) begin
              if (st_q.ifcmd[`MH_CMD_MSK_BIT]) begin
                st_d.objs[sw_idx].msk  = st_q.ifbuf.msk;
                st_d.objs[sw_idx].mask_extended_flag = st_q.ifbuf.mask_extended_flag;
                st_d.objs[sw_idx].mask_direction_flag = st_q.ifbuf.mask_direction_flag;
              end
              if (st_q.ifcmd[`MH_CMD_ARB_BIT]) begin
                st_d.objs[sw_idx].valid = st_q.ifbuf.valid;
                st_d.objs[sw_idx].xtd   = st_q.ifbuf.xtd;
                st_d.objs[sw_idx].dir   = st_q.ifbuf.dir;
                st_d.objs[sw_idx].id    = st_q.ifbuf.id;
              end
              if (st_q.ifcmd[`MH_CMD_CTL_BIT]) begin
                st_d.objs[sw_idx].use_accept_mask  = st_q.ifbuf.use_accept_mask;
                st_d.objs[sw_idx].end_of_buffer    = st_q.ifbuf.end_of_buffer;
                st_d.objs[sw_idx].new_data_flag = st_q.ifbuf.new_data_flag;     // RL13
                st_d.objs[sw_idx].message_lost_flag = st_q.ifbuf.message_lost_flag;
                st_d.objs[sw_idx].rx_irq_enable   = st_q.ifbuf.rx_irq_enable;
                st_d.objs[sw_idx].tx_irq_enable   = st_q.ifbuf.tx_irq_enable;
                st_d.objs[sw_idx].irq_pending_flag = st_q.ifbuf.irq_pending_flag;     // RL22
                st_d.objs[sw_idx].remote_answer_enable  = st_q.ifbuf.remote_answer_enable;
                st_d.objs[sw_idx].transmit_request = st_q.ifbuf.transmit_request;
                st_d.objs[sw_idx].dlc    = st_q.ifbuf.dlc;
              end
              // request bit in the command overrides the buffered one
              if (st_q.ifcmd[`MH_CMD_TXR_BIT]) begin
                st_d.objs[sw_idx].transmit_request = 1'b1;
              end
              if (st_q.ifcmd[`MH_CMD_DA_BIT]) begin
                st_d.objs[sw_idx].data[31:0] = st_q.ifbuf.data[31:0];
              end
              if (st_q.ifcmd[`MH_CMD_DB_BIT]) begin
                st_d.objs[sw_idx].data[63:32] = st_q.ifbuf.data[63:32];
              end
            end else begin
              // buffer receives the flags as they were before clearing
              if (st_q.ifcmd[`MH_CMD_MSK_BIT]) begin
                st_d.ifbuf.msk  = st_q.objs[sw_idx].msk;
                st_d.ifbuf.mask_extended_flag = st_q.objs[sw_idx].mask_extended_flag;
                st_d.ifbuf.mask_direction_flag = st_q.objs[sw_idx].mask_direction_flag;
              end
              if (st_q.ifcmd[`MH_CMD_ARB_BIT]) begin
                st_d.ifbuf.valid = st_q.objs[sw_idx].valid;
                st_d.ifbuf.xtd   = st_q.objs[sw_idx].xtd;
                st_d.ifbuf.dir   = st_q.objs[sw_idx].dir;
                st_d.ifbuf.id    = st_q.objs[sw_idx].id;
              end
              if (st_q.ifcmd[`MH_CMD_CTL_BIT]) begin
                st_d.ifbuf.use_accept_mask  = st_q.objs[sw_idx].use_accept_mask;
                st_d.ifbuf.end_of_buffer    = st_q.objs[sw_idx].end_of_buffer;
                st_d.ifbuf.new_data_flag = st_q.objs[sw_idx].new_data_flag;
                st_d.ifbuf.message_lost_flag = st_q.objs[sw_idx].message_lost_flag;
                st_d.ifbuf.rx_irq_enable   = st_q.objs[sw_idx].rx_irq_enable;
                st_d.ifbuf.tx_irq_enable   = st_q.objs[sw_idx].tx_irq_enable;
                st_d.ifbuf.irq_pending_flag = st_q.objs[sw_idx].irq_pending_flag;
                st_d.ifbuf.remote_answer_enable  = st_q.objs[sw_idx].remote_answer_enable;
                st_d.ifbuf.transmit_request = st_q.objs[sw_idx].transmit_request;
                st_d.ifbuf.dlc    = st_q.objs[sw_idx].dlc;
              end
              if (st_q.ifcmd[`MH_CMD_CLR_BIT]) begin
                st_d.objs[sw_idx].irq_pending_flag = 1'b0;                  // RL22
              end
              if (st_q.ifcmd[`MH_CMD_TXR_BIT]) begin
                st_d.objs[sw_idx].new_data_flag = 1'b0;                  // RL13
              end
              if (st_q.ifcmd[`MH_CMD_DA_BIT]) begin
                st_d.ifbuf.data[31:0] = st_q.objs[sw_idx].data[31:0];
              end
              if (st_q.ifcmd[`MH_CMD_DB_BIT]) begin
                st_d.ifbuf.data[63:32] = st_q.objs[sw_idx].data[63:32];
              end
            end
          end
        end
        default: ;  // summaries and unmapped words ignore writes    RL25
      endcase
    end
    // register reads, answered in the following cycle
    if (BUS.rd) begin
      case (BUS.addr)
        `MH_CTRL_OFS:   st_d.rdata[`MH_CTRL_IE_BIT] = st_q.ie;
        `MH_STAT_OFS: begin
          st_d.rdata[`MH_STAT_RX_BIT] = st_q.rx_ok;
          st_d.rdata[`MH_STAT_TX_BIT] = st_q.tx_ok;
          st_d.rdata[`MH_STAT_PD_BIT] = st_q.stat_pend;
          // reading status is what clears the status interrupt      RL22
          st_d.stat_pend = 1'b0;
          st_d.rx_ok     = 1'b0;
          st_d.tx_ok     = 1'b0;
        end
        `MH_IDR_OFS:    st_d.rdata[15:0] = int_id;                 // RL19
        `MH_IF_CMR_OFS: st_d.rdata[7:0] = st_q.ifcmd;
        `MH_IF_M1R_OFS: st_d.rdata[15:0] = st_q.ifbuf.msk[15:0];
        `MH_IF_M2R_OFS: st_d.rdata[15:0] = {st_q.ifbuf.mask_extended_flag, st_q.ifbuf.mask_direction_flag,
                                             1'b0, st_q.ifbuf.msk[28:16]};
        `MH_IF_A1R_OFS: st_d.rdata[15:0] = st_q.ifbuf.id[15:0];
        `MH_IF_A2R_OFS: st_d.rdata[15:0] = {st_q.ifbuf.valid, st_q.ifbuf.xtd,
                                             st_q.ifbuf.dir, st_q.ifbuf.id[28:16]};
        `MH_IF_MCR_OFS: st_d.rdata[15:0] = {st_q.ifbuf.new_data_flag, st_q.ifbuf.message_lost_flag,
                          st_q.ifbuf.irq_pending_flag, st_q.ifbuf.use_accept_mask, st_q.ifbuf.tx_irq_enable,
                          st_q.ifbuf.rx_irq_enable, st_q.ifbuf.remote_answer_enable, st_q.ifbuf.transmit_request,
                          st_q.ifbuf.end_of_buffer, 3'h0, st_q.ifbuf.dlc};
        `MH_IF_DA1_OFS: st_d.rdata[15:0] = st_q.ifbuf.data[15:0];
        `MH_IF_DA2_OFS: st_d.rdata[15:0] = st_q.ifbuf.data[31:16];
        `MH_IF_DB1_OFS: st_d.rdata[15:0] = st_q.ifbuf.data[47:32];
        `MH_IF_DB2_OFS: st_d.rdata[15:0] = st_q.ifbuf.data[63:48];
        `MH_TXR_LO_OFS: st_d.rdata[15:0] = txr_v[15:0];            // RL25
        `MH_TXR_HI_OFS: st_d.rdata[15:0] = txr_v[31:16];           // RL25
        `MH_NDR_LO_OFS: st_d.rdata[15:0] = ndv_v[15:0];            // RL25
        `MH_NDR_HI_OFS: st_d.rdata[15:0] = ndv_v[31:16];           // RL25
        `MH_IPR_LO_OFS: st_d.rdata[15:0] = ipd_v[15:0];            // RL25
        `MH_IPR_HI_OFS: st_d.rdata[15:0] = ipd_v[31:16];           // RL25
        `MH_MVR_LO_OFS: st_d.rdata[15:0] = val_v[15:0];
        `MH_MVR_HI_OFS: st_d.rdata[15:0] = val_v[31:16];
        default:        st_d.rdata = 32'h0;  // unmapped reads as zero
      endcase
    end
    // transmit completion sets come after software, so they win
    if (TX_DONE.strobe) begin
      st_d.tx_ok = 1'b1;
      if (st_q.objs[TX_DONE.obj].tx_irq_enable) begin
        st_d.objs[TX_DONE.obj].irq_pending_flag = 1'b1;                      // RL15
      end
    end
    // frame reception from the protocol core
    if (RX.strobe && rx_any) begin
      st_d.rx_ok = 1'b1;
      if (st_q.objs[rx_sel].rx_irq_enable) begin
        st_d.objs[rx_sel].irq_pending_flag = 1'b1;                           // RL15
      end
      if (RX.remote) begin
        if (st_q.objs[rx_sel].remote_answer_enable) begin
          st_d.objs[rx_sel].transmit_request = 1'b1;                         // RL10 RL16
        end
      end else begin
        // all eight slots are overwritten, whatever the length      RL18
        st_d.objs[rx_sel].data   = RX.data;                        // RL11
        st_d.objs[rx_sel].dlc    = RX.dlc;                         // RL17
        st_d.objs[rx_sel].new_data_flag = 1'b1;                           // RL13
        if (st_q.objs[rx_sel].new_data_flag && !st_q.objs[rx_sel].dir) begin
          st_d.objs[rx_sel].message_lost_flag = 1'b1;                         // RL14
        end
      end
    end
    if (STATUS_EVENT) begin
      st_d.stat_pend = 1'b1;  // a new event beats a same-cycle status read
    end
    // outgoing frame: receive objects ask by remote frame, length clipped
    st_d.tx.valid  = tx_any && !(TX_DONE.strobe && TX_DONE.obj == tx_sel);
    st_d.tx.obj    = tx_sel;
    st_d.tx.xtd    = st_q.objs[tx_sel].xtd;
    st_d.tx.remote = !st_q.objs[tx_sel].dir;                       // RL10 RL11
    st_d.tx.id     = st_q.objs[tx_sel].id;
    st_d.tx.dlc    = (st_q.objs[tx_sel].dlc > 4'h8) ? 4'h8 : st_q.objs[tx_sel].dlc; // RL17
    st_d.tx.data   = st_q.objs[tx_sel].data;
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  chk_irq_follow: assert property ((st_q.ie && ipd_v != 32'h0) |-> IRQ) // RL21
    else $error("irq missing with pending object");
  chk_status_first: assert property (st_q.stat_pend |-> int_id == 16'h8000) // RL20
    else $error("status interrupt not on top");
  chk_idle_id: assert property ((!st_q.stat_pend && ipd_v == 32'h0) |-> int_id == 16'h0) // RL19
    else $error("identifier nonzero while idle");
  chk_lowest_irq: assert property ((!st_q.stat_pend && ipd_v[0]) |-> int_id == 16'h0001) // RL20
    else $error("object 1 not on top");
  chk_idr_read: assert property ((BUS.rd && BUS.addr == 12'h010) // RL19
      |=> RDATA == {16'h0, $past(int_id)})
    else $error("identifier read wrong");
  chk_rx_new_data_flag: assert property ((RX.strobe && rx_any && !RX.remote) // RL13
      |=> ndv_v[$past(rx_sel)])
    else $error("new data not flagged");
  chk_msg_lost: assert property ((RX.strobe && rx_any && !RX.remote // RL14
      && st_q.objs[rx_sel].new_data_flag && !st_q.objs[rx_sel].dir) |=> st_q.objs[$past(rx_sel)].message_lost_flag)
    else $error("message lost not flagged");
  chk_remote_req: assert property ((RX.strobe && rx_any && RX.remote // RL16
      && st_q.objs[rx_sel].remote_answer_enable) |=> txr_v[$past(rx_sel)])
    else $error("remote frame did not set request");
  chk_invalid_skip: assert property ((RX.strobe && val_v == 32'h0) |-> !rx_any) // RL1
    else $error("invalid object took a frame");
  chk_stat_clear: assert property ((BUS.rd && BUS.addr == 12'h004 && !STATUS_EVENT) // RL22
      |=> !st_q.stat_pend)
    else $error("status read did not clear");
  // outgoing length is clipped, and a completion clears the request that it answers
  chk_tx_clip: assert property (TX.valid |-> TX.dlc <= 4'h8) // RL17
    else $error("outgoing length above eight");
  chk_irq_off: assert property (!st_q.ie |-> !IRQ) // RL21
    else $error("irq while globally disabled");
  chk_done_clear: assert property ((TX_DONE.strobe && !BUS.wr && !(RX.strobe && rx_any)) // RL10
      |=> !txr_v[$past(TX_DONE.obj)])
    else $error("request survived its completion");
  chk_tx_irq: assert property ((TX_DONE.strobe && st_q.objs[TX_DONE.obj].tx_irq_enable) // RL15
      |=> ipd_v[$past(TX_DONE.obj)])
    else $error("transmit did not raise pending");
  chk_rx_dlc: assert property ((RX.strobe && rx_any && !RX.remote) // RL17
      |=> st_q.objs[$past(rx_sel)].dlc == $past(RX.dlc))
    else $error("received length not stored");

  cov_rx_store:  cover property (RX.strobe && rx_any && !RX.remote);
  cov_remote:    cover property (RX.strobe && rx_any && RX.remote);
  cov_tx_done:   cover property (TX_DONE.strobe ##1 IRQ);
  cov_status:    cover property (STATUS_EVENT ##1 int_id == 16'h8000);
endmodule // can_message_object_handler

// [can_core_model.sv]
// behavioural protocol core on the far side of the message handler
`timescale 1ns/1ns
module can_core_model import can_mh_pkg::*; (
  input  wire logic      CLK,
  input  wire logic      RST,
  input  wire tx_frame_t TX,
  output rx_frame_t      RX,
  output tx_done_t       TX_DONE
);
  int unsigned lat = 3; // shortened frame time; the bench makes it slow or prompt
  int unsigned cnt = 0; // cycles the frame in flight has taken
  initial RX = '0;
  initial TX_DONE = '0;
  // one-cycle strobe; fields then turn to their inverse so stale values never match
  task automatic send(rx_frame_t f);
    RX <= f;
    @(posedge CLK);
    f = ~f;
    f.strobe = 1'b0;
    RX <= f;
    @(posedge CLK);
  endtask
  // report success once a request has waited lat cycles; idle object field is inverted
  always @(posedge CLK or posedge RST) begin
    if (RST) begin
      cnt <= 0;
      TX_DONE <= '0;
    end else if (TX.valid && !TX_DONE.strobe && cnt >= lat) begin
      TX_DONE <= '{1'b1, TX.obj};
      cnt <= 0;
    end else begin
      TX_DONE <= '{1'b0, ~TX.obj};
      cnt <= TX.valid ? cnt + 1 : 0;
    end
  end
endmodule // can_core_model

// [tb.sv]
// self-checking bench for the message handler
`timescale 1ns/1ns
module tb import can_mh_pkg::*;;
  logic        CLK = 0, RST = 1, IRQ, STATUS_EVENT = 0;
  bus_req_t    BUS = '0;
  logic [31:0] RDATA, r;
  rx_frame_t   RX;
  tx_frame_t   TX;
  tx_done_t    TX_DONE;
  int          num_errors = 0, comparisons = 0;
  logic [10:0] sid, tid;
  logic [28:0] xid;
  logic [3:0]  n;
  logic [63:0] d64;
  logic [11:0] ra [8] = '{12'h010, 12'h100, 12'h104, 12'h120, 12'h124, 12'h140, 12'h144,
                          12'h0FC};
  always #5 CLK = ~CLK;
  can_message_object_handler i_dut (.CLK(CLK), .RST(RST), .BUS(BUS), .RDATA(RDATA), .RX(RX),
    .TX(TX), .TX_DONE(TX_DONE), .STATUS_EVENT(STATUS_EVENT), .IRQ(IRQ));
  can_core_model i_core (.CLK(CLK), .RST(RST), .TX(TX), .RX(RX), .TX_DONE(TX_DONE));
  // --------------------------------
  // helpers
  // --------------------------------
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one bus cycle then an idle one, so a strobe is never assigned twice in a step
  task automatic op(logic w, logic [11:0] a, logic [31:0] v);
    BUS <= '{wr: w, rd: !w, addr: a, wdata: v};
    @(posedge CLK);
    BUS <= '0;
    #1 r = RDATA;
    @(posedge CLK);
  endtask
  task automatic rc(logic [11:0] a, logic [31:0] e);
    op(0, a, 0);
    chk($sformatf("reg %h", a), e, r);
  endtask
  // load the buffer and commit it to object k
  task automatic obj(logic [5:0] k, logic [15:0] a2, a1, m2, m1, mc);
    op(1, 12'h024, 32'hF3);
    op(1, 12'h028, m1);
    op(1, 12'h02C, m2);
    op(1, 12'h030, a1);
    op(1, 12'h034, a2);
    op(1, 12'h038, mc);
    op(1, 12'h020, k);
  endtask
  // wait for request (0) or completion (1) of a transmission; a miss counts as an error.
  // request fields are read while valid stands; after completion one edge lets it land
  task automatic wtx(logic dn);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 90 && !hit; i++) begin
      @(posedge CLK);
      #1 hit = (dn ? TX_DONE.strobe : TX.valid) === 1'b1;
    end
    chk("tx wait", 1, hit);
    if (dn) @(posedge CLK);
  endtask
  // status first, then the lowest pending object
  function automatic logic [31:0] idr(logic st, logic [31:0] p);
    if (st) return 32'h8000;
    for (int i = 0; i < 32; i++) if (p[i]) return i + 1;
    return 0;
  endfunction
  task automatic complete_run();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // hang guard, far beyond the few hundred cycles the tests take
  initial begin
    #300000;
    num_errors++;
    complete_run();
  end
  // --------------------------------
  // tests
  // --------------------------------
  initial begin
    void'($urandom(85));
    repeat (3) @(posedge CLK);
    RST <= 0;
    @(posedge CLK);
    foreach (ra[i]) begin
      rc(ra[i], 0);
      op(1, ra[i], 32'hFFFF);
      rc(ra[i], 0);
    end
    sid = 11'($urandom);
    tid = 11'($urandom);
    xid = 29'($urandom);
    op(1, 12'h000, 32'h2);
    obj(3, {3'b100, sid, 2'b0}, 0, 0, 0, 16'h0408);
    obj(5, {3'b100, sid, 2'b0}, 0, 0, 0, 16'h0088);
    obj(2, {3'b000, sid, 2'b0}, 0, 0, 0, 16'h0488);
    obj(20, {3'b110, xid[28:16]}, xid[15:0], 16'hDFFF, 16'hFF00, 16'h1488);
    obj(1, {3'b101, tid, 2'b0}, 0, 0, 0, 16'h0A8C);
    // fifo of objects 3 and 5: the third frame overruns the final member
    for (int k = 0; k < 3; k++) begin
      n = 4'($urandom);
      d64 = {$urandom, $urandom};
      i_core.send('{1'b1, 1'b0, 1'b0, {sid, 18'($urandom)}, n, d64});
      rc(12'h120, k ? 32'h14 : 32'h4);
      rc(12'h140, 32'h4);
      rc(12'h010, idr(0, 32'h4));
      chk("irq", 1, IRQ);
    end
    op(1, 12'h024, 32'h7F);
    op(1, 12'h020, 32'h5);
    rc(12'h038, 32'hC080 | n);
    for (int i = 0; i < 4; i++) rc(12'(12'h03C + 4 * i), d64[16 * i +: 16]);
    op(1, 12'h020, 32'h3);
    rc(12'h120, 0);
    rc(12'h010, 0);
    // masked extended object: an unmasked bit blocks, masked ones do not
    i_core.send('{1'b1, 1'b1, 1'b0, xid ^ 29'h100, 4'h8, 64'h0});
    rc(12'h144, 0);
    i_core.send('{1'b1, 1'b1, 1'b0, {xid[28:8], 8'($urandom)}, 4'h8, 64'h0});
    rc(12'h144, 32'h8);
    rc(12'h010, idr(0, 32'h80000));
    STATUS_EVENT <= 1;
    @(posedge CLK);
    STATUS_EVENT <= 0;
    rc(12'h010, idr(1, 32'h80000));
    op(0, 12'h004, 0);
    rc(12'h010, 20);
    op(1, 12'h000, 0);
    chk("irq", 0, IRQ);
    op(1, 12'h000, 32'h2);
    op(1, 12'h024, 32'h08);
    op(1, 12'h020, 32'd20);
    rc(12'h010, 0);
    // slow core: data frame out, then remote answer sets the request again
    i_core.lat = 20;
    op(1, 12'h024, 32'h84);
    op(1, 12'h020, 32'h1);
    wtx(0);
    chk("tx remote", 0, TX.remote);
    chk("tx id", {tid, 18'h0}, TX.id);
    chk("tx dlc", 8, TX.dlc);
    chk("tx obj", 0, TX.obj);
    chk("tx data", 0, TX.data[31:0]);
    wtx(1);
    rc(12'h100, 0);
    rc(12'h140, 1);
    i_core.send('{1'b1, 1'b0, 1'b1, {tid, 18'h0}, 4'h0, 64'h0});
    rc(12'h100, 1);
    wtx(1);
    i_core.lat = 0;
    op(1, 12'h024, 32'h84);
    op(1, 12'h020, 32'h3);
    wtx(0);
    chk("tx remote", 1, TX.remote);
    chk("tx id", {sid, 18'h0}, TX.id);
    chk("tx obj", 2, TX.obj);
    complete_run();
  end
endmodule // tb
